/* File: common/wdr_pkg.sv */
package wdr_pkg;

	// Register addresses on the core I/O port
	localparam logic [7:0] WDR_CAUSE_DATA_ADDR = 8'h54;
	localparam logic [7:0] WDR_IO_ADDR_DELTA = 8'h20;
	localparam logic [7:0] WDR_CAUSE_IO_ADDR = WDR_CAUSE_DATA_ADDR - WDR_IO_ADDR_DELTA;
	localparam logic [7:0] WDR_CTRL_DATA_ADDR = 8'h60;

	// Reset-cause field positions
	localparam int WDR_DEBUG_RESET_BIT = 4;
	localparam int WDR_WATCHDOG_RESET_BIT = 3;
	localparam int WDR_BROWNOUT_RESET_BIT = 2;
	localparam int WDR_PIN_RESET_BIT = 1;
	localparam int WDR_POWER_ON_RESET_BIT = 0;
	localparam int WDR_CAUSE_WIDTH = 5;

	// Control and status field positions
	localparam int WDR_IRQ_FLAG_BIT = 7;
	localparam int WDR_IRQ_ENABLE_BIT = 6;
	localparam int WDR_TSEL_HI_BIT = 5;
	localparam int WDR_CHANGE_ENABLE_BIT = 4;
	localparam int WDR_RESET_ENABLE_BIT = 3;
	localparam int WDR_TSEL_LO_MSB = 2;

	// Reset values
	localparam logic [4:0] WDR_CAUSE_RESET = 5'h01;
	localparam logic [3:0] WDR_TSEL_RESET = 4'h0;
	localparam logic [7:0] WDR_RDATA_RESET = 8'h00;
	localparam logic [2:0] WDR_ZERO_PAD = 3'h0;

	// Change-enable window in system clock cycles
	localparam logic [2:0] WDR_CE_WINDOW_CYC = 3'h4;
	localparam logic [2:0] WDR_CE_LAST_CYC = 3'h1;

	// Time-out periods in oscillator cycles
	localparam int WDR_COUNT_WIDTH = 20;
	localparam logic [20:0] WDR_OSC_BASE_CYCLES = 21'h000800;
	localparam logic [3:0] WDR_TSEL_MAX = 4'h9;
	localparam logic [19:0] WDR_COUNT_ZERO = 20'h00000;
	localparam logic [19:0] WDR_COUNT_ONE = 20'h00001;

	// Rates of the two clocks in hertz
	localparam int WDR_SYS_CLK_HZ = 25000000;
	localparam int WDR_OSC_CLK_HZ = 128000;

	typedef enum logic [1:0] {
		WDR_ST_RUN = 2'b01,
		WDR_ST_PULSE = 2'b10
	} wdr_state_e;

	// Last oscillator count before time-out for a prescaler code
	function automatic logic [19:0] wdr_period_m1(input logic [3:0] sel);
		logic [3:0] s;
		logic [20:0] p;
		s = (sel > WDR_TSEL_MAX) ? WDR_TSEL_MAX : sel;
		p = (WDR_OSC_BASE_CYCLES << s) - 21'h000001;
		return p[19:0];
	endfunction

endpackage

/* File: common/wdr_sync_if.sv */
`timescale 1ns/1ns
interface wdr_sync_if;
	logic raw;
	logic level;
	logic rise;

	// Synchroniser drives the filtered level and its rising-edge pulse
	modport sync_side (
		input raw,
		output level,
		output rise
	);

	// User hands in the pin and reads the result
	modport user_side (
		output raw,
		input level,
		input rise
	);
endinterface

/* File: hdl/wdr_pin_sync.sv */
`timescale 1ns/1ns
module wdr_pin_sync
	import wdr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	wdr_sync_if.sync_side sync
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
	} wdr_sync_s;

	wdr_sync_s st_ff;
	wdr_sync_s nxt_st;

	// Three-stage chain; level follows once stages two and three agree
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = sync.raw;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.rise = 1'b0;
		if (st_ff.s2 == st_ff.s3)
		begin
			nxt_st.level = st_ff.s3;
			nxt_st.rise = st_ff.s3 & ~st_ff.level;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st_ff <= '0;
		else if (i_ce)
			st_ff <= nxt_st;
	end

	assign sync.level = st_ff.level;
	assign sync.rise = st_ff.rise;

endmodule

/* File: hdl/wdr_top.sv */
`timescale 1ns/1ns
// Operation
// (RULE1) Debug-port reset sets its flag; power-on reset or written zero clears it.
// (RULE2) Watchdog system reset sets its flag; power-on or written zero clears it.
// (RULE3) Brown-out reset sets its flag; power-on or written zero clears it.
// (RULE4) Pin reset sets its flag; power-on or written zero clears it.
// (RULE5) Power-on sets its flag; only a written zero clears it.
// (RULE6) Interrupt time-out sets irq flag; vector taken or written one clears.
// (RULE7) Interrupt requested only with global enable, irq enable and pending flag.
// (RULE8) Combined mode: first time-out sets flag; vector clears flag and enable.
// (RULE9) Combined mode: unserviced flag at next time-out gives system reset.
// (RULE10) Fuse unprogrammed: enable pair picks mode; programmed: reset mode always.
// (RULE11) Change-enable clears itself four clock cycles after being written one.
// (RULE12) Clearing reset enable or changing prescaler needs change-enable set.
// (RULE13) Reset enable forced to one while the watchdog reset flag is set.
// (RULE14) Prescaler code selects 2048 to 1048576 oscillator cycles; upper codes reserved.
// (RULE15) Software should restart the counter before shortening the prescaler.
// (RULE16) Start-up software should clear watchdog flag and reset enable.
// (RULE17) Software should read then clear the reset-cause register early.
// (RULE18) Cause register at data offset and offset minus 0x20; control data-only.
// (RULE19) Software writes change and reset enable, then new values within four cycles.
// (RULE20) Programmed fuse locks reset enable at one and irq enable at zero.
// (RULE21) Counter counts cycles of the separate 128kHz oscillator.
// (RULE22) Reset-mode time-out gives a one system-clock-cycle reset pulse.
// (RULE23) Restart command clears the counter so counting begins afresh.
module wdr_top
	import wdr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic i_io_space,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_wdata,
	input wire logic i_global_irq_enable,
	input wire logic i_irq_ack,
	input wire logic i_wdt_restart,
	input wire logic i_always_on_fuse,
	input wire logic i_pin_reset,
	input wire logic i_brownout_reset,
	input wire logic i_debug_reset,
	input wire logic i_osc_128k,
	output logic [7:0] o_rdata,
	output logic o_rdata_valid,
	output logic o_irq_req,
	output logic o_sys_reset
);

	typedef struct packed {
		wdr_state_e state;
		logic [7:0] rdata;
		logic rvalid;
		logic fuse;
		logic irq_flag;
		logic irq_en;
		logic ce;
		logic [2:0] ce_cnt;
		logic rst_en;
		logic [3:0] tsel;
		logic [4:0] cause;
		logic [19:0] count;
		logic irq_req;
		logic sys_rst;
	} wdr_core_s;

	wdr_core_s st_ff;
	wdr_core_s nxt_st;

	wdr_sync_if osc_if();

	logic hit_cause;
	logic hit_ctrl;
	logic wr_cause;
	logic wr_ctrl;
	logic rd_any;
	logic rst_en_eff;
	logic irq_en_eff;
	logic mode_stop;
	logic mode_irq;
	logic mode_reset;
	logic mode_both;
	logic [19:0] period_m1;
	logic other_reset;
	logic [7:0] ctrl_view;

	// Oscillator pin enters through the three-stage filter
	assign osc_if.raw = i_osc_128k;

	wdr_pin_sync u_osc_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.sync(osc_if.sync_side)
	);

	// Address decode; short I/O form reaches only the cause register
	assign hit_cause = i_io_space ? (i_addr == WDR_CAUSE_IO_ADDR)
		: (i_addr == WDR_CAUSE_DATA_ADDR); // RULE18
	assign hit_ctrl = ~i_io_space & (i_addr == WDR_CTRL_DATA_ADDR); // RULE18
	assign wr_cause = i_wr_en & hit_cause;
	assign wr_ctrl = i_wr_en & hit_ctrl;
	assign rd_any = i_rd_en;

	// Effective enables after fuse and flag overrides
	assign rst_en_eff = st_ff.rst_en | st_ff.cause[WDR_WATCHDOG_RESET_BIT]
		| ~st_ff.fuse; // RULE13 RULE20
	assign irq_en_eff = st_ff.irq_en & st_ff.fuse; // RULE20

	// Mode selection from the fuse and the enable pair
	assign mode_stop = ~rst_en_eff & ~irq_en_eff; // RULE10
	assign mode_irq = ~rst_en_eff & irq_en_eff; // RULE10
	assign mode_reset = rst_en_eff & ~irq_en_eff; // RULE10
	assign mode_both = rst_en_eff & irq_en_eff; // RULE10

	// Time-out length from the prescaler code
	assign period_m1 = wdr_period_m1(st_ff.tsel); // RULE14

	// Any reset that is not power-on, from the system controller or ourselves
	assign other_reset = i_pin_reset | i_brownout_reset | i_debug_reset | st_ff.sys_rst;

	// Control register as software sees it
	assign ctrl_view = {st_ff.irq_flag, irq_en_eff, st_ff.tsel[3], st_ff.ce,
		rst_en_eff, st_ff.tsel[WDR_TSEL_LO_MSB:0]};

	// Next-state logic for the whole block
	always_comb
	begin
		logic timeout;
		logic do_reset;
		logic set_irq;
		logic clr_irq;
		logic ack;
		logic [4:0] cause_w;
		timeout = 1'b0;
		do_reset = 1'b0;
		set_irq = 1'b0;
		clr_irq = 1'b0;
		ack = 1'b0;
		cause_w = st_ff.cause;

		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		nxt_st.sys_rst = 1'b0;
		nxt_st.fuse = i_always_on_fuse;

		// Read port, unmapped addresses answer zero
		if (rd_any)
		begin
			nxt_st.rvalid = 1'b1;
			if (hit_cause)
				nxt_st.rdata = {WDR_ZERO_PAD, st_ff.cause}; // RULE18
			else if (hit_ctrl)
				nxt_st.rdata = ctrl_view;
			else
				nxt_st.rdata = WDR_RDATA_RESET;
		end

		// Oscillator counter with restart and wrap at time-out
		if (i_wdt_restart || mode_stop)
			nxt_st.count = WDR_COUNT_ZERO; // RULE23
		else if (osc_if.rise)
		begin
			if (st_ff.count >= period_m1)
			begin
				nxt_st.count = WDR_COUNT_ZERO; // RULE14
				timeout = (st_ff.state == WDR_ST_RUN); // RULE21
			end
			else
				nxt_st.count = st_ff.count + WDR_COUNT_ONE; // RULE21
		end

		// Time-out action per mode
		do_reset = timeout & (mode_reset | (mode_both & st_ff.irq_flag)); // RULE9 RULE10
		set_irq = timeout & (mode_irq | (mode_both & ~st_ff.irq_flag)); // RULE6 RULE8

		// Vector taken clears the flag, and in combined mode the enable too
		ack = i_irq_ack & st_ff.irq_req;
		clr_irq = ack | (wr_ctrl & i_wdata[WDR_IRQ_FLAG_BIT]); // RULE6
		nxt_st.irq_flag = (st_ff.irq_flag & ~clr_irq) | set_irq; // RULE6
		if (ack && mode_both)
			nxt_st.irq_en = 1'b0; // RULE8

		// Control register write
		if (wr_ctrl)
		begin
			if (!(ack && mode_both))
				nxt_st.irq_en = i_wdata[WDR_IRQ_ENABLE_BIT];
			// Reset enable may always be set, cleared only inside the window
			if (i_wdata[WDR_RESET_ENABLE_BIT])
				nxt_st.rst_en = 1'b1;
			else if (st_ff.ce)
				nxt_st.rst_en = 1'b0; // RULE12
			// Prescaler only changes inside the window
			if (st_ff.ce)
				nxt_st.tsel = {i_wdata[WDR_TSEL_HI_BIT],
					i_wdata[WDR_TSEL_LO_MSB:0]}; // RULE12
			// Writing one opens a fresh window
			nxt_st.ce = i_wdata[WDR_CHANGE_ENABLE_BIT];
			nxt_st.ce_cnt = i_wdata[WDR_CHANGE_ENABLE_BIT] ? WDR_CE_WINDOW_CYC
				: '0; // RULE11
		end
		else if (st_ff.ce)
		begin
			// Window closes by itself
			nxt_st.ce_cnt = st_ff.ce_cnt - WDR_CE_LAST_CYC; // RULE11
			if (st_ff.ce_cnt <= WDR_CE_LAST_CYC)
				nxt_st.ce = 1'b0; // RULE11
		end

		// Fuse lock on the interrupt enable
		if (!nxt_st.fuse)
			nxt_st.irq_en = 1'b0; // RULE20

		// Reset sequencer: one-cycle pulse, then back to running
		case (st_ff.state)
			WDR_ST_RUN:
			begin
				if (do_reset)
				begin
					nxt_st.state = WDR_ST_PULSE;
					nxt_st.sys_rst = 1'b1; // RULE22
				end
			end
			WDR_ST_PULSE:
			begin
				nxt_st.state = WDR_ST_RUN; // RULE22
			end
			default:
			begin
				nxt_st.state = WDR_ST_RUN;
			end
		endcase

		// Cause flags: written zero clears, a reset event sets and wins
		if (wr_cause)
			cause_w = st_ff.cause & i_wdata[WDR_CAUSE_WIDTH-1:0]; // RULE1 RULE2 RULE3 RULE4 RULE5
		if (i_debug_reset)
			cause_w[WDR_DEBUG_RESET_BIT] = 1'b1; // RULE1
		if (do_reset)
			cause_w[WDR_WATCHDOG_RESET_BIT] = 1'b1; // RULE2
		if (i_brownout_reset)
			cause_w[WDR_BROWNOUT_RESET_BIT] = 1'b1; // RULE3
		if (i_pin_reset)
			cause_w[WDR_PIN_RESET_BIT] = 1'b1; // RULE4
		nxt_st.cause = cause_w;

		// Other resets return the control register to its reset state
		if (other_reset)
		begin
			nxt_st.irq_flag = 1'b0;
			nxt_st.irq_en = 1'b0;
			nxt_st.ce = 1'b0;
			nxt_st.ce_cnt = '0;
			nxt_st.rst_en = 1'b0;
			nxt_st.tsel = WDR_TSEL_RESET;
			nxt_st.count = WDR_COUNT_ZERO;
		end

		// Registered interrupt request
		nxt_st.irq_req = nxt_st.irq_flag & nxt_st.irq_en & nxt_st.fuse
			& i_global_irq_enable; // RULE7
	end

	// State register; power-on leaves only its own cause flag set
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_ff.state <= WDR_ST_RUN;
			st_ff.rdata <= WDR_RDATA_RESET;
			st_ff.rvalid <= 1'b0;
			st_ff.fuse <= 1'b0;
			st_ff.irq_flag <= 1'b0;
			st_ff.irq_en <= 1'b0;
			st_ff.ce <= 1'b0;
			st_ff.ce_cnt <= '0;
			st_ff.rst_en <= 1'b0;
			st_ff.tsel <= WDR_TSEL_RESET;
			st_ff.cause <= WDR_CAUSE_RESET; // RULE5
			st_ff.count <= WDR_COUNT_ZERO;
			st_ff.irq_req <= 1'b0;
			st_ff.sys_rst <= 1'b0;
		end
		else if (i_ce)
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign o_rdata = st_ff.rdata;
	assign o_rdata_valid = st_ff.rvalid;
	assign o_irq_req = st_ff.irq_req; // RULE7
	assign o_sys_reset = st_ff.sys_rst; // RULE22

endmodule

/* File: verification/wdr_osc_model.sv */
`timescale 1ns/1ns
// Free-running watchdog oscillator, sped up to keep the run short
module wdr_osc_model (
	output logic o_osc
);
	// About eight system clocks per 326 ns period, phase unrelated to the core clock
	initial o_osc = 1'b0;
	always #163 o_osc = ~o_osc;
endmodule

/* File: verification/wdr_top_asserts.sv */
`timescale 1ns/1ns
module wdr_top_asserts
	import wdr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic i_io_space,
	input wire logic i_rd_en,
	input wire logic i_global_irq_enable,
	input wire logic i_irq_ack,
	input wire logic i_always_on_fuse,
	input wire logic [7:0] o_rdata,
	input wire logic o_rdata_valid,
	input wire logic o_irq_req,
	input wire logic o_sys_reset
);
	// Read strobe and decode
	wire rd = i_ce && i_rd_en;
	wire cau = i_io_space ? i_addr == WDR_CAUSE_IO_ADDR : i_addr == WDR_CAUSE_DATA_ADDR;
	wire ctl = !i_io_space && i_addr == WDR_CTRL_DATA_ADDR;
	wire fp = i_ce && !i_always_on_fuse;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_read_valid: assert property (rd |=> o_rdata_valid)
		else $error("read gave no valid");
	a_valid_only: assert property (!rd |=> !o_rdata_valid)
		else $error("valid without read");
	a_unmapped_zero: assert property (rd && !cau && !ctl |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cause_pad: assert property (rd && cau |=> o_rdata[7:5] == WDR_ZERO_PAD)
		else $error("cause upper bits set");
	a_reset_single: assert property (o_sys_reset |=> !o_sys_reset)
		else $error("reset pulse too long");
	a_irq_global: assert property (o_irq_req && $past(i_ce) |-> $past(i_global_irq_enable))
		else $error("irq without global enable");
	a_fuse_lock: assert property (fp [*2] ##0 rd && ctl |=> o_rdata[3] && !o_rdata[6])
		else $error("fuse lock not shown");
	a_fuse_no_irq: assert property (fp [*3] |-> !o_irq_req)
		else $error("irq with fuse programmed");
	a_ack_clears: assert property (o_irq_req && i_irq_ack && i_ce ##1 i_ce |=> !o_irq_req)
		else $error("irq kept after ack");
	c_reset: cover property (o_sys_reset);
	c_irq: cover property (o_irq_req);
	c_ack: cover property (o_irq_req && i_irq_ack);
endmodule
bind wdr_top wdr_top_asserts wdr_top_asserts_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
	.i_ce(i_ce), .i_addr(i_addr), .i_io_space(i_io_space), .i_rd_en(i_rd_en),
	.i_global_irq_enable(i_global_irq_enable), .i_irq_ack(i_irq_ack),
	.i_always_on_fuse(i_always_on_fuse), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
	.o_irq_req(o_irq_req), .o_sys_reset(o_sys_reset));

/* File: verification/test_wdr_top.sv */
`timescale 1ns/1ns
module test_wdr_top;
	import wdr_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic io = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic gie = 1'b0;
	logic fuse = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [4:0] pls = 5'h00;
	logic [7:0] fl [3] = '{8'h02, 8'h04, 8'h10};
	logic [7:0] rdata;
	logic rv;
	logic irq;
	logic sres;
	wire osc;
	int error_cnt = 0;
	int checked = 0;
	int k;
	// Free clock, 40 ns period
	always #20 clk = ~clk;
	wdr_osc_model wdr_osc_model_i (.o_osc(osc));
	wdr_top wdr_top_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_addr(addr),
		.i_io_space(io), .i_wr_en(wr), .i_rd_en(rd), .i_wdata(wd),
		.i_global_irq_enable(gie), .i_irq_ack(pls[4]), .i_wdt_restart(pls[3]),
		.i_always_on_fuse(fuse), .i_pin_reset(pls[0]), .i_brownout_reset(pls[1]),
		.i_debug_reset(pls[2]), .i_osc_128k(osc), .o_rdata(rdata), .o_rdata_valid(rv),
		.o_irq_req(irq), .o_sys_reset(sres));
	// Byte compare
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// Verdict and end of run
	task automatic summarize;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One write access
	task automatic wr_reg(input logic s, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io <= s;
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// One read access, answer checked next cycle
	task automatic rd_reg(input logic s, input logic [7:0] a, input logic [7:0] e, string n);
		@(posedge clk);
		io <= s;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp(n, e, rdata);
	endtask
	// One-cycle pulse on a side input
	task automatic pulse(input int b);
		@(posedge clk);
		pls[b] <= 1'b1;
		@(posedge clk);
		pls[b] <= 1'b0;
	endtask
	// Bounded wait for irq (0) or reset pulse (1)
	task automatic wait_hi(input logic s, output int n);
		for (n = 0; n < 20000; n++)
		begin
			@(posedge clk);
			#1;
			if ((s ? sres : irq) === 1'b1)
				break;
		end
		if (n == 20000)
		begin
			cmp("wait", 8'h01, 8'h00);
			summarize();
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(1, WDR_CAUSE_IO_ADDR, 8'h01, "cause io");
		rd_reg(0, WDR_CAUSE_DATA_ADDR, 8'h01, "cause data");
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h00, "ctrl");
		rd_reg(1, 8'h40, 8'h00, "ctrl io");
		wr_reg(1, WDR_CAUSE_IO_ADDR, 8'h1E);
		rd_reg(0, WDR_CAUSE_DATA_ADDR, 8'h00, "por clear");
		for (int i = 0; i < 3; i++)
		begin
			pulse(i);
			rd_reg(1, WDR_CAUSE_IO_ADDR, fl[i], "cause src");
			wr_reg(1, WDR_CAUSE_IO_ADDR, 8'h00);
		end
		$display("test cause done");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h05);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h00, "tsel guard");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h08);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h00);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h08, "wde guard");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h18);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h18, "ce cy2");
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h18, "ce cy4");
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h08, "ce cy6");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h18);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h0D);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h0D, "timed set");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h18);
		repeat (5) @(posedge clk);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h00);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h0D, "late set");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h18);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h00);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h00, "timed clear");
		@(posedge clk);
		fuse <= 1'b0;
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h08, "fuse lock");
		@(posedge clk);
		fuse <= 1'b1;
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h00, "fuse off");
		$display("test control done");
		@(posedge clk);
		gie <= 1'b1;
		pulse(3);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h48);
		wait_hi(0, k);
		cmp("period", 8'h01, {7'h00, k > 16600 && k < 16800});
		rd_reg(1, WDR_CAUSE_IO_ADDR, 8'h00, "no reset");
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'hC8, "irq flag");
		@(posedge clk);
		gie <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		cmp("irq gated", 8'h00, {7'h00, irq});
		@(posedge clk);
		gie <= 1'b1;
		wait_hi(0, k);
		pulse(4);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h08, "vector");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h48);
		wait_hi(0, k);
		wait_hi(1, k);
		rd_reg(1, WDR_CAUSE_IO_ADDR, 8'h08, "wd flag");
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h18);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h00);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h08, "wde forced");
		wr_reg(1, WDR_CAUSE_IO_ADDR, 8'h00);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h18);
		wr_reg(0, WDR_CTRL_DATA_ADDR, 8'h00);
		rd_reg(0, WDR_CTRL_DATA_ADDR, 8'h00, "wde free");
		$display("test timeout done");
		summarize();
	end
endmodule
